//--- rtl/buck_boost_ch2_config_regs.sv
// Configuration register pair and enable decode for buck-boost output two.
`timescale 1ns/1ps
`default_nettype none
`include "ch2_consts.svh"

// Function
// - Target voltage is 500mV plus 25mV times code.
// - Discharge load when bit set, channel off.
// - Selector codes 0-3 pick sequencer slot.
// - Codes 4,5 force off; 6,7 force on.
module buck_boost_ch2_config_regs
  import ch2_pkg::*;
(
  input  wire logic        mclk_in,                      // Register domain clock, 40 MHz.
  input  wire logic        reset_in,                     // Synchronous active-high reset.
  input  wire logic [7:0]  reg_addr_in,                  // Register offset from the host interface.
  input  wire logic        reg_wr_in,                    // One-cycle write strobe.
  input  wire logic        reg_rd_in,                    // One-cycle read strobe.
  input  wire logic [7:0]  reg_wdata_in,                 // Write data.
  input  wire logic [3:0]  power_sequencer_slot_active_in, // Slot levels from the sequencer, same clock.
  output var  logic [7:0]  reg_rdata_out,                // Read data, valid the cycle after a read strobe.
  output var  logic [7:0]  ch2_target_voltage_code_out,  // Stored target voltage code.
  output var  logic [12:0] ch2_target_mv_out,            // Target voltage in millivolts.
  output var  logic [1:0]  power_sequencer_slot_out,     // Slot the channel follows in slot mode.
  output var  logic        ch2_slot_mode_out,            // High while the channel follows a slot.
  output var  logic        ch2_enable_out,               // Channel enable to the regulator core.
  output var  logic        ch2_active_discharge_enable_out, // Stored discharge enable bit.
  output var  logic        ch2_discharge_out             // Discharge load switch control.
);

  // All state lives in one packed word: both registers, the read answer and the decoded controls.
  // Registering the decode from the next values adds no latency and keeps every output glitch-free.
  state_t state_reg;   // Registered state.
  state_t state_next;  // Next value of the state.

  // Next-state logic: register writes, read capture, and decode of the channel controls.
  // Decode works from the next register values so that every output lines up with the stored bits.
  always_comb begin
    logic [2:0] sel;
    sel = 3'h0;
    state_next = state_reg;
    // Writes store all eight bits; reserved bits are kept as plain storage.
    // Writes to any other offset fall through and leave both registers alone.
    if (reg_wr_in) begin
      if (reg_addr_in == `CH2_TARGET_VOLTAGE_OFS) begin
        state_next.tv = reg_wdata_in;
      end
      if (reg_addr_in == `CH2_ENABLE_DISCHARGE_OFS) begin
        state_next.cfg = reg_wdata_in;
      end
    end
    // Reads return the stored value before any write in the same cycle.
    // A read and a write in one cycle therefore hand back the old contents.
    if (reg_rd_in) begin
      case (reg_addr_in)
        `CH2_TARGET_VOLTAGE_OFS:   state_next.rdata = state_reg.tv;
        `CH2_ENABLE_DISCHARGE_OFS: state_next.rdata = state_reg.cfg;
        default:                   state_next.rdata = `CH2_UNMAPPED_READ;
      endcase
    end
    // Reserved codes are not trapped; the scale simply continues past the legal range.
    state_next.mv = 13'(`CH2_V_BASE_MV + `CH2_V_STEP_MV * {5'h00, state_next.tv});
    // The selector is taken from the value about to be stored, so a write shows one edge later.
    sel = state_next.cfg[`CH2_SEL_MSB:`CH2_SEL_LSB];
    // Upper selector bit clear means slot mode; otherwise the middle bit picks on or off.
    if (!sel[2]) begin
      // Codes 0 to 3 hand the channel to the numbered sequencer slot for both ramps.
      state_next.mode      = SEL_SLOT;
      state_next.slot      = sel[1:0];
      state_next.slot_mode = 1'b1;
    end else if (!sel[1]) begin
      // Codes 4 and 5 hold the channel off; the slot field keeps its last value.
      state_next.mode      = SEL_FORCE_OFF;
      state_next.slot_mode = 1'b0;
    end else begin
      // Codes 6 and 7 hold the channel on, whatever the sequencer is doing.
      state_next.mode      = SEL_FORCE_ON;
      state_next.slot_mode = 1'b0;
    end
    // Slot levels come from logic on this clock, so they are read without a synchroniser.
    case (state_next.mode)
      SEL_SLOT:      state_next.enable = power_sequencer_slot_active_in[state_next.slot];
      SEL_FORCE_OFF: state_next.enable = 1'b0;
      SEL_FORCE_ON:  state_next.enable = 1'b1;
      default:       state_next.enable = 1'b0;
    endcase
    // The load only pulls down a disabled output, never one that is regulating.
    state_next.discharge = state_next.cfg[`CH2_ADE_BIT] & ~state_next.enable;
  end

  // State register with synchronous reset to the documented register values.
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      // Both registers return to their reset values.
      state_reg.tv        <= `CH2_TARGET_VOLTAGE_RST;
      state_reg.cfg       <= `CH2_ENABLE_DISCHARGE_RST;
      // Read data clears so a stale answer is never mistaken for a fresh one.
      state_reg.rdata     <= 8'h00;
      // Decoded outputs match what the reset contents decode to: slot 0, channel off until slot 0 rises.
      state_reg.mv        <= `CH2_V_BASE_MV;
      state_reg.mode      <= SEL_SLOT;
      state_reg.slot      <= 2'h0;
      state_reg.slot_mode <= 1'b1;
      state_reg.enable    <= 1'b0;
      state_reg.discharge <= 1'b0;
    end else begin
      // Every field moves together, so outputs never mix old and new register contents.
      state_reg <= state_next;
    end
  end

  // Outputs come straight from the state register.
  // Slot mode has its own flop so that this output needs no decode after the register.
  assign reg_rdata_out                   = state_reg.rdata;
  assign ch2_target_voltage_code_out     = state_reg.tv;
  assign ch2_target_mv_out               = state_reg.mv;
  assign power_sequencer_slot_out        = state_reg.slot;
  assign ch2_slot_mode_out               = state_reg.slot_mode;
  assign ch2_enable_out                  = state_reg.enable;
  assign ch2_active_discharge_enable_out = state_reg.cfg[`CH2_ADE_BIT];
  assign ch2_discharge_out               = state_reg.discharge;

  // Checks on the registered outputs.
  // Every check samples on the register clock and sleeps while reset is held.
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);

  // A write to the voltage register.
  sequence tv_write_s;
    reg_wr_in && reg_addr_in == `CH2_TARGET_VOLTAGE_OFS;
  endsequence

  // A write to the configuration register.
  sequence cfg_write_s;
    reg_wr_in && reg_addr_in == `CH2_ENABLE_DISCHARGE_OFS;
  endsequence

  // The millivolt output always sits on the linear scale of the stored code.
  AST_MV_SCALE: assert property (
    ch2_target_mv_out == 13'(`CH2_V_BASE_MV + `CH2_V_STEP_MV * {5'h00, ch2_target_voltage_code_out}))
    else $error("Millivolt output does not match code scale.");

  // A voltage write lands in the code and the millivolt output one edge later.
  AST_TV_WRITE: assert property (
    tv_write_s |=> ch2_target_voltage_code_out == $past(reg_wdata_in) &&
                   ch2_target_mv_out == 13'(`CH2_V_BASE_MV + `CH2_V_STEP_MV * {5'h00, $past(reg_wdata_in)}))
    else $error("Voltage write not reflected in code and millivolts.");

  // The load is on exactly when its bit is set and the channel is off.
  AST_DISCHARGE: assert property (
    ch2_discharge_out == (ch2_active_discharge_enable_out && !ch2_enable_out))
    else $error("Discharge load does not follow enable bit and channel state.");

  // Writing a slot code routes that slot's level to the enable at the next edge.
  AST_SLOT_FOLLOW: assert property (
    cfg_write_s ##0 !reg_wdata_in[2] |=> ch2_slot_mode_out &&
      power_sequencer_slot_out == $past(reg_wdata_in[1:0]) &&
      ch2_enable_out == $past(power_sequencer_slot_active_in[reg_wdata_in[1:0]]))
    else $error("Slot selector does not route the sequencer slot.");

  // Codes 4 and 5 switch the channel off at the next edge.
  AST_FORCE_OFF: assert property (
    cfg_write_s ##0 reg_wdata_in[2:1] == 2'h2 |=> !ch2_enable_out && !ch2_slot_mode_out)
    else $error("Force-off code left the channel on.");

  // Codes 6 and 7 switch the channel on at the next edge, whatever the slots say.
  AST_FORCE_ON: assert property (
    cfg_write_s ##0 reg_wdata_in[2:1] == 2'h3 |=> ch2_enable_out && !ch2_slot_mode_out)
    else $error("Force-on code did not turn the channel on.");

  // Configuration readback returns all eight stored bits.
  AST_READBACK: assert property (
    reg_rd_in && reg_addr_in == `CH2_ENABLE_DISCHARGE_OFS |=>
      reg_rdata_out == {$past(state_reg.cfg)})
    else $error("Configuration readback differs from stored value.");

  // Any other offset reads back as the fixed unmapped value.
  AST_UNMAPPED: assert property (
    reg_rd_in && reg_addr_in != `CH2_TARGET_VOLTAGE_OFS && reg_addr_in != `CH2_ENABLE_DISCHARGE_OFS |=>
      reg_rdata_out == `CH2_UNMAPPED_READ)
    else $error("Unmapped read did not return zero.");

  // A read of the voltage register.
  sequence tv_read_s;
    reg_rd_in && reg_addr_in == `CH2_TARGET_VOLTAGE_OFS;
  endsequence

  // Voltage readback returns the code that stood when the read was taken.
  AST_TV_READBACK: assert property (
    tv_read_s |=> reg_rdata_out == $past(ch2_target_voltage_code_out))
    else $error("Voltage readback differs from stored code.");

  // Without a write to it, the voltage code never moves.
  AST_TV_HOLD: assert property (
    !(reg_wr_in && reg_addr_in == `CH2_TARGET_VOLTAGE_OFS) |=>
      $stable(ch2_target_voltage_code_out))
    else $error("Voltage code changed without a write.");

  // Without a write to it, the discharge enable bit never moves.
  AST_CFG_HOLD: assert property (
    !(reg_wr_in && reg_addr_in == `CH2_ENABLE_DISCHARGE_OFS) |=>
      $stable(ch2_active_discharge_enable_out))
    else $error("Discharge enable bit changed without a write.");

  // Forcing the channel off with the discharge bit set connects the load at the next edge.
  AST_LOAD_ON_DISABLE: assert property (
    cfg_write_s ##0 (reg_wdata_in[3] && reg_wdata_in[2:1] == 2'h2) |=> ch2_discharge_out)
    else $error("Discharge load not connected on a disabled channel.");

  // In slot mode the channel follows its slot's level one edge later.
  AST_SLOT_TRACK: assert property (
    ch2_slot_mode_out && !(reg_wr_in && reg_addr_in == `CH2_ENABLE_DISCHARGE_OFS) |=>
      ch2_enable_out == $past(power_sequencer_slot_active_in[power_sequencer_slot_out]))
    else $error("Enable does not follow the assigned sequencer slot.");

  // A forced channel ignores the slots: enable and slot stay put until the selector is rewritten.
  AST_FORCE_HOLD: assert property (
    !ch2_slot_mode_out && !(reg_wr_in && reg_addr_in == `CH2_ENABLE_DISCHARGE_OFS) |=>
      $stable(ch2_enable_out) && $stable(power_sequencer_slot_out))
    else $error("Forced channel moved without a selector write.");

  // Read data stands until the next read strobe.
  AST_RDATA_HOLD: assert property (
    !reg_rd_in |=> $stable(reg_rdata_out))
    else $error("Read data changed without a read.");

endmodule // buck_boost_ch2_config_regs
`default_nettype wire

//--- pkg/ch2_consts.svh
// Offsets, field positions, reset values and scale constants for the channel two configuration registers.
`ifndef CH2_CONSTS_SVH
`define CH2_CONSTS_SVH

// Register offsets on the device's internal register port.
`define CH2_TARGET_VOLTAGE_OFS    8'h0c
`define CH2_ENABLE_DISCHARGE_OFS  8'h0d

// Reset values of both registers.
`define CH2_TARGET_VOLTAGE_RST    8'h00
`define CH2_ENABLE_DISCHARGE_RST  8'h00

// Field positions inside the enable and discharge register.
`define CH2_ADE_BIT               3
`define CH2_SEL_MSB               2
`define CH2_SEL_LSB               0

// Answer to a read of an unmapped offset.
`define CH2_UNMAPPED_READ         8'h00

// Linear voltage scale in millivolts: base plus step times code.
`define CH2_V_BASE_MV             13'h01f4
`define CH2_V_STEP_MV             13'h0019

// Highest legal code; codes above it are reserved for software.
`define CH2_TV_MAX_LEGAL          8'h8c

`endif

//--- pkg/ch2_pkg.sv
// Types shared by the channel two configuration register bank.
`default_nettype none
package ch2_pkg;

  // Operating mode decoded from the three-bit enable selector.
  typedef enum logic [1:0] {
    SEL_SLOT,
    SEL_FORCE_OFF,
    SEL_FORCE_ON
  } sel_mode_t;

  // Whole state of the register bank, registered as one word.
  typedef struct packed {
    logic [7:0]  tv;         // Target voltage code register.
    logic [7:0]  cfg;        // Enable and discharge register.
    logic [7:0]  rdata;      // Read data held for the host interface.
    logic [12:0] mv;         // Target voltage in millivolts.
    sel_mode_t   mode;       // Decoded selector mode.
    logic [1:0]  slot;       // Assigned sequencer slot.
    logic        slot_mode;  // Channel follows a sequencer slot.
    logic        enable;     // Channel enabled.
    logic        discharge;  // Discharge load connected.
  } state_t;

endpackage : ch2_pkg
`default_nettype wire

//--- sim/tb_buck_boost_ch2_config_regs.sv
// Self-checking testbench for the channel two configuration register bank.
`timescale 1ns/1ps
`default_nettype none
module tb_buck_boost_ch2_config_regs;
  logic        mclk_in = 1'b0;   // Register clock, 40 MHz.
  logic        reset_in = 1'b1;  // Synchronous reset, held at start.
  logic [7:0]  addr = 8'h00;     // Register offset driven by the bench.
  logic        wr = 1'b0;        // Write strobe.
  logic        rd = 1'b0;        // Read strobe.
  logic [7:0]  wdata = 8'h00;    // Write data.
  logic [3:0]  slot_act = 4'h0;  // Sequencer slot levels.
  logic [7:0]  rdata, code;      // Read data and stored code.
  logic [12:0] mv;               // Target in millivolts.
  logic [1:0]  slot;             // Assigned slot.
  logic        slot_mode, en, ade, dis;
  int          error_cnt = 0;
  int          checks_done = 0;
  // Free-running clock, half period 12.5 ns.
  always #12.5 mclk_in = ~mclk_in;
  buck_boost_ch2_config_regs u_buck_boost_ch2_config_regs (
    .mclk_in(mclk_in), .reset_in(reset_in), .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_wdata_in(wdata), .power_sequencer_slot_active_in(slot_act), .reg_rdata_out(rdata),
    .ch2_target_voltage_code_out(code), .ch2_target_mv_out(mv), .power_sequencer_slot_out(slot),
    .ch2_slot_mode_out(slot_mode), .ch2_enable_out(en), .ch2_active_discharge_enable_out(ade),
    .ch2_discharge_out(dis));
  // Four-state compare; an unknown never counts as a match.
  task automatic check(input logic [12:0] seen, input logic [12:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  // One-cycle write strobe, launched and released on falling edges.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_in);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge mclk_in);
    wr = 1'b0;
  endtask
  // Read strobe; data is settled by the next falling edge.
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(negedge mclk_in);
    addr = a;
    rd = 1'b1;
    @(negedge mclk_in);
    rd = 1'b0;
    check({5'h00, rdata}, {5'h00, exp}, what);
  endtask
  // Reset values of both registers and the millivolt, enable and slot-mode outputs.
  task automatic test_reset();
    rd_reg(8'h0c, 8'h00, "tv reset");
    rd_reg(8'h0d, 8'h00, "cfg reset");
    check(mv, 13'h01f4, "mv reset");
    check({12'h000, en}, 13'h0000, "en reset");
    check({12'h000, slot_mode}, 13'h0001, "slot mode reset");
    $display("test_reset done");
  endtask
  // Legal codes from both ends of the scale; reserved codes are never written.
  task automatic test_voltage();
    logic [7:0] codes [5] = '{8'h00, 8'h01, 8'h46, 8'h8b, 8'h8c};
    foreach (codes[i]) begin
      wr_reg(8'h0c, codes[i]);
      check({5'h00, code}, {5'h00, codes[i]}, "code");
      check(mv, 13'h01f4 + 13'h0019 * {5'h00, codes[i]}, "mv");
      rd_reg(8'h0c, codes[i], "tv readback");
    end
    $display("test_voltage done");
  endtask
  // Every selector code with discharge on and off; slot levels one-hot, then inverted with no write between.
  task automatic test_select();
    logic [2:0] s;
    logic       a, exp_en;
    for (int i = 0; i < 16; i++) begin
      s = i[2:0];
      a = i[3];
      wr_reg(8'h0d, {4'h0, a, s});
      for (int k = 0; k < 2; k++) begin
        @(negedge mclk_in);
        slot_act = (k == 1) ? ~(4'h1 << s[1:0]) : (4'h1 << s[1:0]);
        repeat (2) @(negedge mclk_in);
        exp_en = (s < 3'h4) ? slot_act[s[1:0]] : (s >= 3'h6);
        check({12'h000, en}, {12'h000, exp_en}, "enable");
        check({12'h000, dis}, {12'h000, a & ~exp_en}, "discharge");
        check({12'h000, ade}, {12'h000, a}, "ade bit");
        check({12'h000, slot_mode}, {12'h000, s < 3'h4}, "slot mode");
        if (s < 3'h4) check({11'h000, slot}, {11'h000, s[1:0]}, "slot");
      end
    end
    $display("test_select done");
  endtask
  // One unmapped offset, reserved bits, and a read colliding with a write.
  task automatic test_misc();
    wr_reg(8'h0b, 8'h55);
    rd_reg(8'h0b, 8'h00, "unmapped read");
    check({5'h00, code}, 13'h008c, "unmapped write ignored");
    // Reserved bits are written as zero; the bias low-power control sits outside this bank.
    wr_reg(8'h0d, 8'h06);
    rd_reg(8'h0d, 8'h06, "reserved bits zero");
    check({12'h000, en}, 13'h0001, "forced on");
    @(negedge mclk_in);
    addr = 8'h0c;
    wdata = 8'h33;
    wr = 1'b1;
    rd = 1'b1;
    @(negedge mclk_in);
    wr = 1'b0;
    rd = 1'b0;
    check({5'h00, rdata}, 13'h008c, "collision old value");
    rd_reg(8'h0c, 8'h33, "collision new value");
    $display("test_misc done");
  endtask
  // The one place where the run ends.
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Main sequence; reset spans ten clock cycles.
  initial begin
    repeat (10) @(negedge mclk_in);
    reset_in = 1'b0;
    test_reset();
    test_voltage();
    test_select();
    test_misc();
    report_and_stop();
  end
  // Watchdog well past the roughly 175 cycles the tests need.
  initial begin
    #(25 * 5000);
    error_cnt++;
    report_and_stop();
  end
endmodule // tb_buck_boost_ch2_config_regs
`default_nettype wire
